/* File: hw/mrl_top.sv */
// result-code and line option state with dcd, hang-up and answer-role control
//
// Chosen here: the register offsets and the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
module mrl_top
  import mrl_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYC_DFLT
)(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic carrier_present,
  input wire logic long_space_rx,
  input wire logic dtr,
  input wire logic ring_evt,
  input wire logic connect_evt,
  input wire logic v32_link,
  input wire logic line_quality_bad,
  output logic dcd,
  output logic off_hook,
  output logic tx_space,
  output logic answer_tone_en,
  output logic originate_mode,
  output logic retrain_req,
  output logic busy_det_en,
  output logic dialtone_det_en,
  output logic [8:0] result_enable,
  output logic line_speed_en,
  output logic report_dce_speed,
  output logic ext_carrier_en,
  output logic ext_protocol_en,
  output logic hangup_done,
  output logic cmd_error
);
  logic [31:0] opt_q;
  logic [31:0] mask_q;
  logic [31:0] prof0_q;
  logic [31:0] prof1_q;
  logic role_q;
  logic discard_q;
  logic err_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic qa_q;
  logic wt_q;
  logic auto_q;
  logic dtr_q;
  logic [31:0] div_q;
  logic tick;
  logic [7:0] tcnt_q;
  logic [7:0] lscnt_q;
  logic [31:0] wmask;
  mrl_state_t st_q;
  mrl_pat_t pat;
  logic [1:0] w_opt;
  logic [2:0] x_opt;
  logic [7:0] xmask;
  logic [7:0] s10;
  logic [7:0] s9;
  logic req;
  logic wr;
  logic cmd_wr;
  logic [3:0] op;
  logic do_reset;
  logic do_hang;
  logic dtr_drop;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        old[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return old;
  endfunction : merge

  function automatic mrl_pat_t pick_pat(input logic [1:0] cd, input logic [2:0] pr, input logic big);
    mrl_pat_t p;
    p = PAT_B;
    if (pr == 3'h5 && !big)
    begin
      p = (cd == 2'h1) ? PAT_E : PAT_A;
    end
    else if (pr == 3'h0 || pr == 3'h5 || pr == 3'h6)
    begin
      p = (cd == 2'h0) ? PAT_A : ((cd == 2'h1) ? PAT_B : PAT_D);
    end
    return p;
  endfunction : pick_pat

  assign w_opt = opt_q[F_W +: 2];
  assign x_opt = opt_q[F_X +: 3];
  assign xmask = mask_q[7:0];
  assign s10 = mask_q[15:8];
  assign s9 = mask_q[23:16];
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr = req && wb_we_i;
  assign cmd_wr = wr && wb_adr_i == OFS_CMD && wb_sel_i[0];
  assign op = wb_dat_i[3:0];
  assign do_reset = cmd_wr && !discard_q && op == OP_RESET;
  assign dtr_drop = dtr_q && !dtr && opt_q[F_DT +: 2] == 2'h2;
  assign do_hang = (cmd_wr && !discard_q && op == OP_HANGUP) || dtr_drop;
  assign tick = div_q == 32'(TICK_CYC - 1);
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign cmd_error = err_q;

  // wishbone slave: one wait state, unmapped reads zero
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= req;
      case (wb_adr_i)
        OFS_OPT: rdat_q <= opt_q;
        OFS_MASK: rdat_q <= mask_q;
        OFS_STAT: rdat_q <= {3'h0, result_enable, 7'h00, role_q, 2'h0, discard_q, err_q,
                             dcd, off_hook, 2'(pat), 1'b0, 3'(st_q)};
        OFS_PROF0: rdat_q <= prof0_q;
        OFS_PROF1: rdat_q <= prof1_q;
        default: rdat_q <= 32'h0000_0000;
      endcase
    end
  end

  // option registers: written only when accepted; option, mask and role reloaded by soft reset, profiles kept
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      opt_q <= OPT_RST;
      mask_q <= MASK_RST;
      role_q <= 1'b0;
      prof0_q <= OPT_RST;
      prof1_q <= OPT_RST;
    end
    else if (do_reset)
    begin
      opt_q <= (wb_dat_i[8] ? prof1_q : prof0_q) & ~(32'h1 << F_ROLE);
      role_q <= wb_dat_i[8] ? prof1_q[F_ROLE] : prof0_q[F_ROLE];
      mask_q <= MASK_RST;
    end
    else if (wr && !discard_q)
    begin
      if (wb_adr_i == OFS_OPT)
      begin
        opt_q <= merge(opt_q, wb_dat_i, wb_sel_i) & ~(32'h1 << F_ROLE);
      end
      if (wb_adr_i == OFS_MASK)
      begin
        mask_q <= (mask_q & ~wmask) | (wb_dat_i & wmask);
      end
      if (wb_adr_i == OFS_PROF0)
      begin
        prof0_q <= merge(prof0_q, wb_dat_i, wb_sel_i);
      end
      if (wb_adr_i == OFS_PROF1)
      begin
        prof1_q <= merge(prof1_q, wb_dat_i, wb_sel_i);
      end
      if (cmd_wr && op == OP_ROLE && wb_dat_i[15:8] <= 8'h01)
      begin
        role_q <= wb_dat_i[8];
      end
    end
  end

  // command-line discard after soft reset, error flag
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      discard_q <= 1'b0;
      err_q <= 1'b0;
    end
    else
    begin
      if (do_reset)
      begin
        discard_q <= 1'b1;
      end
      else if (cmd_wr && op == OP_EOL)
      begin
        discard_q <= 1'b0;
      end
      if (cmd_wr && !discard_q && op == OP_ROLE && wb_dat_i[15:8] > 8'h01)
      begin
        err_q <= 1'b1;
      end
      else if (cmd_wr && !discard_q)
      begin
        err_q <= 1'b0;
      end
    end
  end

  // tenth-second tick
  always_ff @(posedge clock)
  begin
    if (!rst_n || tick)
    begin
      div_q <= 32'h0000_0000;
    end
    else
    begin
      div_q <= div_q + 32'h0000_0001;
    end
  end

  // call state machine
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      st_q <= ST_IDLE;
      tcnt_q <= 8'h00;
      lscnt_q <= 8'h00;
      dtr_q <= 1'b0;
      qa_q <= 1'b0;
      wt_q <= 1'b0;
      auto_q <= 1'b0;
    end
    else
    begin
      dtr_q <= dtr;
      if (st_q != ST_ONLINE || !long_space_rx)
      begin
        lscnt_q <= 8'h00;
      end
      else if (tick && lscnt_q != LONG_SPACE_TICKS)
      begin
        lscnt_q <= lscnt_q + 8'h01;
      end
      if (do_reset)
      begin
        st_q <= ST_HANG;
      end
      else
      begin
        case (st_q)
          ST_IDLE:
          begin
            tcnt_q <= 8'h00;
            if (cmd_wr && !discard_q && op == OP_DIAL)
            begin
              st_q <= ST_CONN;
              qa_q <= wb_dat_i[A_QA];
              wt_q <= wb_dat_i[A_WT];
              auto_q <= 1'b0;
            end
            else if (ring_evt && mask_q[31:24] != 8'h00)
            begin
              st_q <= ST_CONN;
              auto_q <= 1'b1;
            end
          end
          ST_CONN:
          begin
            if (do_hang)
            begin
              st_q <= ST_HANG;
            end
            else if (connect_evt)
            begin
              st_q <= ST_ONLINE;
            end
          end
          ST_ONLINE:
          begin
            tcnt_q <= 8'h00;
            if (do_hang)
            begin
              st_q <= opt_q[F_LS] ? ST_BREAK : ST_HANG;
            end
            else if (opt_q[F_LS] && lscnt_q == LONG_SPACE_TICKS)
            begin
              st_q <= ST_HANG;
            end
            else if (!carrier_present)
            begin
              st_q <= ST_LOST;
            end
          end
          ST_LOST:
          begin
            if (do_hang)
            begin
              st_q <= opt_q[F_LS] ? ST_BREAK : ST_HANG;
            end
            else if (carrier_present && tcnt_q >= s9)
            begin
              st_q <= ST_ONLINE;
            end
            else if (!carrier_present && s10 != DELAY_NEVER && tcnt_q >= s10)
            begin
              st_q <= ST_HANG;
            end
            else if (!carrier_present && tcnt_q != 8'h00 && !tick)
            begin
              tcnt_q <= tcnt_q;
            end
            if (tick && tcnt_q != 8'hFF)
            begin
              tcnt_q <= tcnt_q + 8'h01;
            end
          end
          ST_BREAK:
          begin
            if (tcnt_q == BREAK_TICKS)
            begin
              st_q <= ST_HANG;
            end
            else if (tick)
            begin
              tcnt_q <= tcnt_q + 8'h01;
            end
          end
          ST_HANG:
          begin
            st_q <= ST_IDLE;
            qa_q <= 1'b0;
            wt_q <= 1'b0;
            auto_q <= 1'b0;
          end
          default: st_q <= ST_IDLE;
        endcase
      end
    end
  end

  // line outputs
  assign off_hook = st_q != ST_IDLE && st_q != ST_HANG;
  assign tx_space = st_q == ST_BREAK;
  assign hangup_done = st_q == ST_HANG;
  assign originate_mode = auto_q ? role_q : 1'b1;
  assign answer_tone_en = st_q == ST_CONN && auto_q && !role_q;
  assign pat = opt_q[F_FD] ? pick_pat(opt_q[F_CD +: 2], opt_q[F_PR +: 3], s10 == DELAY_NEVER)
                           : PAT_E;

  always_comb
  begin
    case (pat)
      PAT_A: dcd = 1'b1;
      PAT_B: dcd = st_q == ST_ONLINE && carrier_present;
      PAT_D: dcd = st_q == ST_IDLE || (st_q == ST_ONLINE && carrier_present) || st_q == ST_HANG;
      PAT_E: dcd = st_q == ST_ONLINE || st_q == ST_LOST;
      default: dcd = 1'b1;
    endcase
  end

  // result-code selection
  always_comb
  begin
    busy_det_en = x_opt == 3'h3 || x_opt == 3'h4;
    dialtone_det_en = x_opt == 3'h2 || x_opt == 3'h4;
    case (x_opt)
      3'h0: result_enable = 9'h01F;
      3'h1: result_enable = 9'h03F;
      3'h2: result_enable = 9'h07F;
      3'h3: result_enable = 9'h0BF;
      default: result_enable = 9'h0FF;
    endcase
    if (qa_q)
    begin
      result_enable = result_enable | 9'h180;
    end
    if (wt_q)
    begin
      result_enable = result_enable | 9'h0C0;
    end
    line_speed_en = x_opt != 3'h0;
    report_dce_speed = line_speed_en && (w_opt == 2'h2 || xmask[0]);
    ext_carrier_en = line_speed_en && (w_opt == 2'h1 || xmask[2]);
    ext_protocol_en = line_speed_en && (w_opt == 2'h1 || xmask[3]);
  end

  // auto retrain request
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      retrain_req <= 1'b0;
    end
    else
    begin
      retrain_req <= st_q == ST_ONLINE && v32_link && line_quality_bad && opt_q[F_RT];
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  x0_codes_a: assert property (x_opt == 3'h0 && !qa_q && !wt_q |-> result_enable == 9'h01F && !line_speed_en)
    else $error("x0 result set wrong");
  x3_codes_a: assert property (x_opt == 3'h3 && !qa_q && !wt_q |-> result_enable == 9'h0BF && busy_det_en)
    else $error("x3 result set wrong");
  w2_speed_a: assert property (w_opt == 2'h2 && x_opt != 3'h0 |-> report_dce_speed)
    else $error("w2 lost line speed");
  w1_ext_a: assert property (w_opt == 2'h1 && x_opt != 3'h0 |-> ext_carrier_en && ext_protocol_en)
    else $error("w1 lost extended messages");
  role_err_a: assert property (cmd_wr && !discard_q && op == OP_ROLE && wb_dat_i[15:8] > 8'h01
                               |=> err_q && $stable(role_q))
    else $error("bad role accepted");
  reset_hook_a: assert property (do_reset |=> st_q == ST_HANG ##1 !off_hook && discard_q)
    else $error("soft reset did not hang up");
  break_len_a: assert property ($rose(tx_space) |-> tx_space [*8])
    else $error("break ended early");
  pat_a_a: assert property (pat == PAT_A |-> dcd)
    else $error("pattern a dropped dcd");
  pat_b_a: assert property (pat == PAT_B && st_q == ST_ONLINE && !carrier_present && !do_hang
                            |=> !dcd)
    else $error("pattern b missed carrier loss");
  tone_a: assert property (answer_tone_en |-> auto_q && !role_q && st_q == ST_CONN)
    else $error("answer tone with originate role");
  retrain_a: assert property (retrain_req |-> $past(v32_link) && $past(opt_q[F_RT]))
    else $error("retrain off v32");
  cv_online: cover property (st_q == ST_CONN ##[1:50] st_q == ST_ONLINE);
  cv_lost_back: cover property (st_q == ST_LOST ##[1:50] st_q == ST_ONLINE);
  cv_break: cover property (st_q == ST_ONLINE ##1 st_q == ST_BREAK);
  cv_reset: cover property (do_reset);
endmodule : mrl_top
`default_nettype wire

/* File: hw/mrl_pkg.sv */
// package: offsets, fields, reset values and timing for the result and line option block
package mrl_pkg;
  // bus register byte addresses
  localparam logic [4:0] OFS_OPT = 5'h00;
  localparam logic [4:0] OFS_MASK = 5'h04;
  localparam logic [4:0] OFS_CMD = 5'h08;
  localparam logic [4:0] OFS_STAT = 5'h0C;
  localparam logic [4:0] OFS_PROF0 = 5'h10;
  localparam logic [4:0] OFS_PROF1 = 5'h14;
  // option word fields (also the stored profile layout)
  localparam int F_W = 0;       // connect-report option, 2 bits
  localparam int F_X = 4;       // call-progress option, 3 bits
  localparam int F_LS = 8;      // long-space option
  localparam int F_RT = 9;      // auto-retrain option
  localparam int F_CD = 12;     // carrier-detect option, 2 bits
  localparam int F_PR = 16;     // link protocol, 3 bits
  localparam int F_FD = 20;     // full duplex
  localparam int F_DT = 21;     // terminal-ready option, 2 bits
  localparam int F_ROLE = 24;   // auto-answer role (profile only)
  localparam logic [31:0] OPT_RST = 32'h0010_0041;
  // mask word: extended_result_mask, carrier_loss_hangup_delay, carrier_detect_delay, auto_answer_rings
  localparam logic [31:0] MASK_RST = 32'h0006_0E00;
  localparam logic [7:0] DELAY_NEVER = 8'hFF;
  // command word: op in [3:0], argument in [15:8]
  localparam logic [3:0] OP_ROLE = 4'h1;
  localparam logic [3:0] OP_RESET = 4'h2;
  localparam logic [3:0] OP_HANGUP = 4'h3;
  localparam logic [3:0] OP_DIAL = 4'h4;
  localparam logic [3:0] OP_EOL = 4'h5;
  localparam int A_QA = 8;      // dial: quiet-answer modifier seen
  localparam int A_WT = 9;      // dial: wait-for-dial-tone modifier seen
  // dcd patterns
  typedef enum logic [1:0] {PAT_A = 2'h0, PAT_B = 2'h1, PAT_D = 2'h2, PAT_E = 2'h3} mrl_pat_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_CONN = 3'h1,
    ST_ONLINE = 3'h2,
    ST_LOST = 3'h3,
    ST_BREAK = 3'h4,
    ST_HANG = 3'h5
  } mrl_state_t;
  // timing
  localparam int CLK_HZ = 25000000;
  localparam int TICK_MS = 100;
  localparam int LONG_SPACE_MS = 1600;
  localparam int BREAK_MS = 4000;
  localparam int TICK_CYC_DFLT = CLK_HZ / 1000 * TICK_MS;
  localparam logic [7:0] LONG_SPACE_TICKS = 8'(LONG_SPACE_MS / TICK_MS);
  localparam logic [7:0] BREAK_TICKS = 8'(BREAK_MS / TICK_MS);
endpackage : mrl_pkg

/* File: dv/mrl_dte.sv */
// terminal-side bus master model issuing option writes, reads and commands
`timescale 1ns/10ps
`default_nettype none
module mrl_dte (
  input wire logic clock,
  input wire logic wb_ack_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_cyc_o,
  output logic wb_stb_o,
  output logic wb_we_o,
  output logic [4:0] wb_adr_o,
  output logic [3:0] wb_sel_o,
  output logic [31:0] wb_dat_o
);
  initial
  begin
    wb_cyc_o = 1'h0;
    wb_stb_o = 1'h0;
    wb_we_o = 1'h0;
    wb_adr_o = 5'h00;
    wb_sel_o = 4'h0;
    wb_dat_o = 32'h0;
  end
  // one classic cycle; held until ack is seen, released at the edge that samples it
  task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clock);
    wb_cyc_o <= 1'h1;
    wb_stb_o <= 1'h1;
    wb_we_o <= w;
    wb_adr_o <= a;
    wb_sel_o <= 4'hF;
    wb_dat_o <= d;
    do @(posedge clock); while (wb_ack_i !== 1'h1);
    q = wb_dat_i;
    wb_cyc_o <= 1'h0;
    wb_stb_o <= 1'h0;
    wb_adr_o <= ~a;
    wb_dat_o <= ~d;
  endtask : xfer
endmodule : mrl_dte
`default_nettype wire

/* File: dv/mrl_top_tb_top.sv */
// testbench for the result and line option block
`timescale 1ns/10ps
`default_nettype none
module mrl_top_tb_top import mrl_pkg::*;;
  localparam int TC = 4;
  localparam int NR = 22;
  typedef struct packed {
    logic [31:0] opt;
    logic [15:0] msk;
    logic [1:0] pat;
    logic dcd;
    logic [1:0] bd;
    logic [8:0] res;
    logic [3:0] flg;
  } mrl_row_t;
  // option word, mask low half, pattern, idle dcd, busy/tone, result codes, speed/dce/carrier/protocol
  localparam mrl_row_t ROWS [NR] = '{
    '{32'h00101000, 16'h0E00, 2'h1, 1'h0, 2'h0, 9'h01F, 4'h0},
    '{32'h00101010, 16'h0E00, 2'h1, 1'h0, 2'h0, 9'h03F, 4'h8},
    '{32'h00101020, 16'h0E00, 2'h1, 1'h0, 2'h1, 9'h07F, 4'h8},
    '{32'h00101030, 16'h0E00, 2'h1, 1'h0, 2'h2, 9'h0BF, 4'h8},
    '{32'h00101040, 16'h0E00, 2'h1, 1'h0, 2'h3, 9'h0FF, 4'h8},
    '{32'h00101041, 16'h0E00, 2'h1, 1'h0, 2'h3, 9'h0FF, 4'hB},
    '{32'h00101042, 16'h0E00, 2'h1, 1'h0, 2'h3, 9'h0FF, 4'hC},
    '{32'h00101040, 16'h0E0C, 2'h1, 1'h0, 2'h3, 9'h0FF, 4'hB},
    '{32'h00101040, 16'h0E01, 2'h1, 1'h0, 2'h3, 9'h0FF, 4'hC},
    '{32'h00101042, 16'h0E0C, 2'h1, 1'h0, 2'h3, 9'h0FF, 4'hF},
    '{32'h00101041, 16'h0E01, 2'h1, 1'h0, 2'h3, 9'h0FF, 4'hF},
    '{32'h00101001, 16'h0E0C, 2'h1, 1'h0, 2'h0, 9'h01F, 4'h0},
    '{32'h00100041, 16'h0E00, 2'h0, 1'h1, 2'h3, 9'h0FF, 4'hB},
    '{32'h00102041, 16'h0E00, 2'h2, 1'h1, 2'h3, 9'h0FF, 4'hB},
    '{32'h00110041, 16'h0E00, 2'h1, 1'h0, 2'h3, 9'h0FF, 4'hB},
    '{32'h00142041, 16'h0E00, 2'h1, 1'h0, 2'h3, 9'h0FF, 4'hB},
    '{32'h00151041, 16'h0E00, 2'h3, 1'h0, 2'h3, 9'h0FF, 4'hB},
    '{32'h00152041, 16'h0E00, 2'h0, 1'h1, 2'h3, 9'h0FF, 4'hB},
    '{32'h00152041, 16'hFF00, 2'h2, 1'h1, 2'h3, 9'h0FF, 4'hB},
    '{32'h00151041, 16'hFF00, 2'h1, 1'h0, 2'h3, 9'h0FF, 4'hB},
    '{32'h00162041, 16'h0E00, 2'h2, 1'h1, 2'h3, 9'h0FF, 4'hB},
    '{32'h00001041, 16'h0E00, 2'h3, 1'h0, 2'h3, 9'h0FF, 4'hB}
  };
  logic clock = 1'h0;
  logic rst_n = 1'h0;
  logic carrier_present = 1'h1, dtr = 1'h1;
  logic long_space_rx = 1'h0, ring_evt = 1'h0, connect_evt = 1'h0, v32_link = 1'h0, line_quality_bad = 1'h0;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [4:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, v;
  logic dcd, off_hook, tx_space, answer_tone_en, originate_mode, retrain_req, busy_det_en, dialtone_det_en;
  logic line_speed_en, report_dce_speed, ext_carrier_en, ext_protocol_en, hangup_done, cmd_error;
  logic [8:0] result_enable;
  int miscompares = 0, checks_done = 0;

  mrl_top #(.TICK_CYC(TC)) mrl_top_inst (.clock, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .carrier_present, .long_space_rx, .dtr, .ring_evt,
    .connect_evt, .v32_link, .line_quality_bad, .dcd, .off_hook, .tx_space, .answer_tone_en,
    .originate_mode, .retrain_req, .busy_det_en, .dialtone_det_en, .result_enable, .line_speed_en,
    .report_dce_speed, .ext_carrier_en, .ext_protocol_en, .hangup_done, .cmd_error);
  mrl_dte mrl_dte_inst (.clock, .wb_ack_i(wb_ack_o), .wb_dat_i(wb_dat_o), .wb_cyc_o(wb_cyc_i),
    .wb_stb_o(wb_stb_i), .wb_we_o(wb_we_i), .wb_adr_o(wb_adr_i), .wb_sel_o(wb_sel_i), .wb_dat_o(wb_dat_i));

  initial
  begin
    forever #20 clock = ~clock;
  end

  task automatic close_out;
    if (miscompares == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    mrl_dte_inst.xfer(1'h1, a, d, q);
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [31:0] q);
    mrl_dte_inst.xfer(1'h0, a, 32'h0, q);
  endtask : rd

  task automatic cmd(input logic [3:0] op, input logic [7:0] arg);
    wr(OFS_CMD, {16'h0000, arg, 4'h0, op});
  endtask : cmd

  task automatic online;
    cmd(OP_DIAL, 8'h00);
    @(posedge clock);
    connect_evt <= 1'h1;
    @(posedge clock);
    connect_evt <= 1'h0;
    @(negedge clock);
  endtask : online

  task automatic ring;
    @(posedge clock);
    ring_evt <= 1'h1;
    @(posedge clock);
    ring_evt <= 1'h0;
    repeat (2) @(negedge clock);
  endtask : ring

  // wait for the hang-up moment, check its timing, dcd there and on-hook after
  task automatic hang_wait(input int lo, input int hi, input logic d);
    int k;
    k = 0;
    while (hangup_done !== 1'h1 && k < 400)
    begin
      @(negedge clock);
      k++;
    end
    chk(k >= lo && k <= hi, 1'h1);
    if (d !== 1'hx)
      chk(dcd, d);
    @(negedge clock);
    chk(off_hook, 1'h0);
  endtask : hang_wait

  initial
  begin
    repeat (20000) @(posedge clock);
    miscompares++;
    $display("mismatch at %0t: timeout", $time);
    close_out();
  end

  initial
  begin
    repeat (4) @(posedge clock);
    rst_n <= 1'h1;
    for (int i = 0; i < NR; i++)
    begin
      wr(OFS_MASK, {16'h0006, ROWS[i].msk});
      wr(OFS_OPT, ROWS[i].opt);
      @(negedge clock);
      chk(dcd, ROWS[i].dcd);
      chk({busy_det_en, dialtone_det_en}, ROWS[i].bd);
      chk(result_enable, ROWS[i].res);
      chk({line_speed_en, report_dce_speed, ext_carrier_en, ext_protocol_en}, ROWS[i].flg);
      rd(OFS_STAT, v);
      chk(v[5:4], ROWS[i].pat);
    end
    wr(OFS_MASK, MASK_RST);
    // dial modifiers and carrier tracking
    wr(OFS_OPT, 32'h00101000);
    cmd(OP_DIAL, 8'h01);
    @(negedge clock);
    chk(result_enable, 9'h19F);
    chk(dcd, 1'h0);
    @(posedge clock);
    connect_evt <= 1'h1;
    @(posedge clock);
    connect_evt <= 1'h0;
    @(negedge clock);
    chk(dcd, 1'h1);
    @(posedge clock);
    carrier_present <= 1'h0;
    @(negedge clock);
    chk(dcd, 1'h0);
    repeat (8 * TC) @(posedge clock);
    carrier_present <= 1'h1;
    repeat (2 * TC) @(negedge clock);
    chk(dcd, 1'h1);
    @(posedge clock);
    carrier_present <= 1'h0;
    hang_wait(13 * TC, 16 * TC, 1'h0);
    @(posedge clock);
    carrier_present <= 1'h1;
    cmd(OP_DIAL, 8'h02);
    @(negedge clock);
    chk(result_enable, 9'h0DF);
    cmd(OP_HANGUP, 8'h00);
    // pattern D through a carrier-loss hang-up
    wr(OFS_OPT, 32'h00102041);
    online();
    chk(dcd, 1'h1);
    @(posedge clock);
    carrier_present <= 1'h0;
    @(negedge clock);
    chk(dcd, 1'h0);
    hang_wait(13 * TC, 16 * TC, 1'h1);
    @(posedge clock);
    carrier_present <= 1'h1;
    // long space received
    wr(OFS_OPT, 32'h00101041);
    online();
    @(posedge clock);
    long_space_rx <= 1'h1;
    repeat (20 * TC) @(negedge clock);
    chk(off_hook, 1'h1);
    @(posedge clock);
    long_space_rx <= 1'h0;
    wr(OFS_OPT, 32'h00101141);
    @(posedge clock);
    long_space_rx <= 1'h1;
    hang_wait(15 * TC, 18 * TC, 1'h0);
    @(posedge clock);
    long_space_rx <= 1'h0;
    // break before on-hook, by command and by terminal-ready drop
    online();
    cmd(OP_HANGUP, 8'h00);
    @(negedge clock);
    chk(tx_space, 1'h1);
    hang_wait(39 * TC, 42 * TC, 1'hx);
    wr(OFS_OPT, 32'h00501141);
    online();
    @(posedge clock);
    dtr <= 1'h0;
    repeat (2) @(negedge clock);
    chk(tx_space, 1'h1);
    hang_wait(38 * TC, 42 * TC, 1'hx);
    @(posedge clock);
    dtr <= 1'h1;
    // auto retrain
    wr(OFS_OPT, 32'h00101241);
    online();
    @(posedge clock);
    v32_link <= 1'h1;
    line_quality_bad <= 1'h1;
    repeat (3) @(negedge clock);
    chk(retrain_req, 1'h1);
    @(posedge clock);
    v32_link <= 1'h0;
    repeat (3) @(negedge clock);
    chk(retrain_req, 1'h0);
    @(posedge clock);
    v32_link <= 1'h1;
    wr(OFS_OPT, 32'h00101041);
    repeat (2) @(negedge clock);
    chk(retrain_req, 1'h0);
    @(posedge clock);
    line_quality_bad <= 1'h0;
    v32_link <= 1'h0;
    cmd(OP_HANGUP, 8'h00);
    // answer role
    wr(OFS_MASK, 32'h01060E00);
    cmd(OP_ROLE, 8'h02);
    @(negedge clock);
    chk(cmd_error, 1'h1);
    rd(OFS_STAT, v);
    chk(v[12], 1'h0);
    cmd(OP_ROLE, 8'h01);
    rd(OFS_STAT, v);
    chk(v[12], 1'h1);
    chk(cmd_error, 1'h0);
    ring();
    chk(off_hook, 1'h1);
    chk(originate_mode, 1'h1);
    chk(answer_tone_en, 1'h0);
    cmd(OP_HANGUP, 8'h00);
    cmd(OP_ROLE, 8'h00);
    ring();
    chk(originate_mode, 1'h0);
    cmd(OP_HANGUP, 8'h00);
    // soft reset with profile recall and discard
    wr(OFS_PROF1, 32'h01152041);
    wr(OFS_MASK, 32'h0106FF0C);
    cmd(OP_DIAL, 8'h00);
    cmd(OP_RESET, 8'h01);
    @(negedge clock);
    chk(off_hook, 1'h0);
    rd(OFS_OPT, v);
    chk(v, 32'h00152041);
    rd(OFS_MASK, v);
    chk(v, MASK_RST);
    wr(OFS_OPT, 32'h00100041);
    cmd(OP_ROLE, 8'h00);
    rd(OFS_OPT, v);
    chk(v, 32'h00152041);
    rd(OFS_STAT, v);
    chk({v[12], v[9]}, 2'h3);
    cmd(OP_EOL, 8'h00);
    cmd(OP_RESET, 8'h00);
    cmd(OP_EOL, 8'h00);
    rd(OFS_OPT, v);
    chk(v, OPT_RST);
    rd(OFS_STAT, v);
    chk({v[12], v[9]}, 2'h0);
    // hardware reset in mid-call, then unmapped accesses
    cmd(OP_ROLE, 8'h02);
    cmd(OP_DIAL, 8'h00);
    @(posedge clock);
    rst_n <= 1'h0;
    repeat (4) @(posedge clock);
    rst_n <= 1'h1;
    @(negedge clock);
    chk({cmd_error, off_hook, retrain_req}, 3'h0);
    chk(result_enable, 9'h0FF);
    rd(OFS_PROF1, v);
    chk(v, OPT_RST);
    rd(OFS_MASK, v);
    chk(v, MASK_RST);
    wr(5'h18, 32'hFFFFFFFF);
    rd(5'h1C, v);
    chk(v, 32'h0);
    rd(OFS_OPT, v);
    chk(v, OPT_RST);
    close_out();
  end
endmodule : mrl_top_tb_top
`default_nettype wire
